/* File: design/pdc_chain.sv */
// Notes on behaviour
// RL1: Set-address to address 0 adopts function code as address, answers OK plus address.
// RL2: Command to address 7, code 000, is run mode; answer OK, data 0x000.
// RL3: Own address 1-6 with code 000 switches low-side switch on; OK 0x000.
// RL4: Own address 1-6 with code 111 switches low-side switch off; OK 0x111.
// RL5: Programmed device accepts set-address at its own address and takes new one.
// RL6: Good command answers 0x1E1; transmission error during command answers 0x1E2.
// RL7: Addresses 1-6 select fixed slots for source IDs 0 and 2; 0, 7 none.
// RL8: Programming address 7 is ignored; the old address stays.
// RL9: Programming-mode entry before any set-address disables chain operation.
// RL10: Supply error or test mode: chain commands ignored; other errors no effect.
// RL11: Supply error in phases 2 and 3 ignores sync pulses until it clears.
// RL12: Temperature or memory error still lets init data be transmitted.
// RL13: Blocking error in phase 3 holds run mode; ready sent before run.
// RL14: Unprogrammed lock region sends ready-but-not-locked instead of ready.
// RL15: Latch select clear: an error message clears temporary error status.
// RL16: Standard codes: offset 0x1F4, self-test 0x1EA; supply, not-locked no code.
// RL17: Extended codes 0x1EF, 0x1EE, 0x1ED, 0x1EC, 0x1EB, 0x1EA.
// RL18: Auto-clear: supply to temperature temporary; memory, self-test held to reset.
// RL19: Offset or self-test error on either channel reported on both channels.
// RL20: Receiver precedes set-address by 31 to 60 sync pulses.
// RL21: Framing or CRC error in a command gives no response.
// RL22: Responses use the source-ID-0 slot of the device address.
// RL23: After run-mode answer all commands ignored; phases 2, 3 follow sync pulses.
// RL24: Unprogrammed device acts only on set-address to address 000.
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module pdc_chain
  import pdc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // AXI4-Lite slave
  input  wire logic [7:0] s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  output logic [1:0]      s_axi_bresp,
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  input  wire logic [7:0] s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  output logic [31:0]     s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready,
  // Decoded commands from the supply-line receiver
  input  wire logic       cmd_valid,
  input  wire logic [2:0] cmd_addr,
  input  wire logic [2:0] cmd_fc,
  input  wire logic       cmd_frame_err,
  input  wire logic       cmd_crc_err,
  input  wire logic       cmd_tx_err,
  input  wire logic       pme_valid,
  input  wire logic       sync_pulse,
  // Internal error conditions
  input  wire logic       supply_err,
  input  wire logic       comm_err,
  input  wire logic       test_mode_on,
  input  wire logic [1:0] offset_err,
  input  wire logic       temp_err,
  input  wire logic       mem_err,
  input  wire logic [1:0] selftest_err,
  input  wire logic       lock_region_programmed,
  // Command responses
  output logic            resp_valid,
  output logic [9:0]      response_code_word,
  output logic [9:0]      response_data_word,
  output pdc_slot_t       resp_slot,
  output pdc_slot_t       sid2_slot,
  output logic            lss_on,
  // Initialization and normal-mode frames
  output logic            init_tx_valid,
  output pdc_init_kind_t  init_tx_kind,
  output logic            run_mode,
  output logic            frame_valid,
  output logic            frame_is_err,
  output logic [9:0]      frame_code
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic pdc_slot_t slot_sid0(input logic [2:0] a);
    unique case (a)
      3'h1:    slot_sid0 = SL_DC0;
      3'h2:    slot_sid0 = SL_DC1_L;
      3'h3:    slot_sid0 = SL_DC2_L;
      3'h4:    slot_sid0 = SL_DC1_H;
      3'h5:    slot_sid0 = SL_DC2_H;
      3'h6:    slot_sid0 = SL_DC3_H;
      default: slot_sid0 = SL_NONE;
    endcase
  endfunction

  function automatic pdc_slot_t slot_sid2(input logic [2:0] a);
    unique case (a)
      3'h1:    slot_sid2 = SL_DC1_L;
      3'h2:    slot_sid2 = SL_DC2_L;
      3'h3:    slot_sid2 = SL_DC0;
      3'h4:    slot_sid2 = SL_DC2_H;
      3'h5:    slot_sid2 = SL_DC3_H;
      3'h6:    slot_sid2 = SL_DC0;
      default: slot_sid2 = SL_NONE;
    endcase
  endfunction

  // Returns {has_code, code}; held errors win over temporary ones
  function automatic logic [10:0] err_code(input logic [5:0] f, input logic ext);
    err_code = {1'b0, RD_ZERO};
    if (ext) begin
      if (f[FL_SELF]) err_code = {1'b1, EC_SELFTEST}; //RL17
      else if (f[FL_MEM]) err_code = {1'b1, EC_EXT_MEM};
      else if (f[FL_OFFSET]) err_code = {1'b1, EC_EXT_OFFSET};
      else if (f[FL_TEMP]) err_code = {1'b1, EC_EXT_TEMP};
      else if (f[FL_TEST]) err_code = {1'b1, EC_EXT_TEST};
      else if (f[FL_COMM]) err_code = {1'b1, EC_EXT_COMM};
    end else begin
      if (f[FL_SELF]) err_code = {1'b1, EC_SELFTEST}; //RL16
      else if (f[FL_OFFSET]) err_code = {1'b1, EC_STD_OFFSET};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic           awready;
    logic           wready;
    logic           aw_got;
    logic           w_got;
    logic [7:0]     awaddr;
    logic [31:0]    wdata;
    logic [3:0]     wstrb;
    logic           bvalid;
    logic [1:0]     bresp;
    logic           arready;
    logic           rvalid;
    logic [31:0]    rdata;
    logic [1:0]     rresp;
    logic [2:0]     ctrl;
    pdc_state_t     st;
    logic           run;
    logic [2:0]     addr;
    logic [7:0]     cnt;
    logic [5:0]     flags;
    logic           resp_valid;
    logic [9:0]     rc;
    logic [9:0]     rd;
    pdc_slot_t      slot;
    pdc_slot_t      slot2;
    logic           lss;
    logic           init_valid;
    pdc_init_kind_t init_kind;
    logic           frame_valid;
    logic           frame_err;
    logic [9:0]     frame_code;
  } pdc_regs_t;

  pdc_regs_t s_reg;
  pdc_regs_t s_next;

  logic [5:0]  err_in;
  logic [10:0] code_now;
  logic        cmd_ok;
  logic        chain_blocked;
  logic [2:0]  new_addr;

  assign err_in = {|selftest_err, mem_err, temp_err, |offset_err, test_mode_on, comm_err}; //RL19
  assign code_now = err_code(s_reg.flags, s_reg.ctrl[CTRL_EXT_BIT]);
  assign cmd_ok = cmd_valid & ~cmd_frame_err & ~cmd_crc_err; //RL21
  // A disabled chain behaves like a blocked one: commands are dropped unanswered
  assign chain_blocked = supply_err | test_mode_on | ~s_reg.ctrl[CTRL_CHAIN_BIT]; //RL10
  assign new_addr = cmd_fc;

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_next = s_reg;
    s_next.resp_valid = 1'b0;
    s_next.init_valid = 1'b0;
    s_next.frame_valid = 1'b0;

    // AXI4-Lite write path: address and data accepted in either order
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = AXI_OKAY;
      if (s_reg.awaddr[7:2] == REG_CTRL_OFS[7:2]) begin
        if (s_reg.wstrb[0]) begin
          s_next.ctrl = s_reg.wdata[2:0];
        end
      end else if (s_reg.awaddr[7:2] != REG_STATUS_OFS[7:2]) begin
        s_next.bresp = AXI_SLVERR;
      end
    end
    // Ready drops in the capture cycle so a held valid is never taken twice
    s_next.awready = ~s_next.aw_got & ~(s_axi_awvalid & s_reg.awready);
    s_next.wready = ~s_next.w_got & ~(s_axi_wvalid & s_reg.wready);

    // AXI4-Lite read path
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = AXI_OKAY;
      s_next.rdata = '0;
      if (s_axi_araddr[7:2] == REG_CTRL_OFS[7:2]) begin
        s_next.rdata[2:0] = s_reg.ctrl;
      end else if (s_axi_araddr[7:2] == REG_STATUS_OFS[7:2]) begin
        s_next.rdata[STAT_ADDR_LSB +: 3] = s_reg.addr;
        s_next.rdata[STAT_STATE_LSB +: 3] = s_reg.st;
        s_next.rdata[STAT_LSS_BIT] = s_reg.lss;
        s_next.rdata[STAT_FLAGS_LSB +: 6] = s_reg.flags;
      end else begin
        s_next.rresp = AXI_SLVERR;
      end
    end
    s_next.arready = ~s_next.rvalid & ~(s_axi_arvalid & s_reg.arready);

    // Error status: a new error always wins over a clear in the same cycle
    s_next.flags = s_reg.flags | err_in;

    unique case (s_reg.st)
      ST_WAIT_ADDR: begin
        if (pme_valid) begin
          s_next.st = ST_OFF; //RL9
        end else if (cmd_ok && !chain_blocked && cmd_addr == ADDR_NONE) begin //RL24
          s_next.slot = slot_sid0(s_reg.addr);
          s_next.rd = RD_ZERO;
          if (cmd_tx_err) begin
            s_next.resp_valid = 1'b1;
            s_next.rc = RC_ERR; //RL6
          end else if (new_addr != ADDR_BCAST && new_addr != ADDR_NONE) begin //RL8
            s_next.addr = new_addr; //RL1
            s_next.st = ST_PROG;
            s_next.resp_valid = 1'b1;
            s_next.rc = RC_OK; //RL6
            s_next.rd = {7'h00, new_addr};
            s_next.slot = slot_sid0(new_addr); //RL22
            s_next.slot2 = slot_sid2(new_addr); //RL7
          end
        end
      end
      ST_PROG: begin
        if (cmd_ok && !chain_blocked &&
            (cmd_addr == s_reg.addr || cmd_addr == ADDR_BCAST)) begin
          s_next.rc = RC_OK;
          s_next.rd = RD_ZERO;
          s_next.slot = slot_sid0(s_reg.addr); //RL22
          s_next.resp_valid = 1'b1;
          if (cmd_tx_err) begin
            s_next.rc = RC_ERR; //RL6
          end else if (cmd_addr == ADDR_BCAST) begin
            if (cmd_fc == FC_ZERO) begin
              s_next.st = ST_PH2; //RL2
              s_next.cnt = '0;
            end else begin
              s_next.resp_valid = 1'b0;
            end
          end else if (cmd_fc == FC_ZERO) begin
            s_next.lss = 1'b1; //RL3
          end else if (cmd_fc == FC_ONES) begin
            s_next.lss = 1'b0; //RL4
            s_next.rd = RD_SW_OFF;
          end else begin
            s_next.addr = new_addr; //RL5
            s_next.rd = {7'h00, new_addr};
            s_next.slot = slot_sid0(new_addr);
            s_next.slot2 = slot_sid2(new_addr); //RL7
          end
        end
      end
      // Commands are no longer decoded from here on
      ST_PH2: begin
        if (sync_pulse && !supply_err) begin //RL11 RL23
          s_next.init_valid = 1'b1; //RL12
          s_next.init_kind = IK_DATA;
          s_next.cnt = s_reg.cnt + 8'h01;
          if (s_reg.cnt == PH2_SYNC_CNT - 8'h01) begin
            s_next.st = ST_PH3;
            s_next.cnt = '0;
          end
        end
      end
      ST_PH3: begin
        // Each accepted pulse sends a ready message, so run mode is never
        // entered before one has gone out after the error cleared
        if (sync_pulse && !supply_err) begin //RL11 RL13
          s_next.init_valid = 1'b1; //RL12
          s_next.init_kind = lock_region_programmed ? IK_READY : IK_READY_NL; //RL14
          if (s_reg.cnt >= PH3_SYNC_CNT - 8'h01) begin
            s_next.st = ST_RUN;
          end else begin
            s_next.cnt = s_reg.cnt + 8'h01;
          end
        end
      end
      ST_RUN: begin
        if (sync_pulse && !supply_err) begin //RL18
          s_next.frame_valid = 1'b1;
          s_next.frame_err = code_now[10];
          s_next.frame_code = code_now[9:0]; //RL16 RL17 RL19
          if (code_now[10] && !s_reg.ctrl[CTRL_LATCH_BIT]) begin
            s_next.flags = (s_reg.flags & ~FL_TEMPORARY) | err_in; //RL15 RL18
          end
        end
      end
      ST_OFF: begin
      end
    endcase
    // Run indicator is kept in its own flop so the output needs no decode
    // after the register; it follows the state with no extra delay
    s_next.run = (s_next.st == ST_RUN);
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.ctrl <= CTRL_RESET;
      s_reg.st <= ST_WAIT_ADDR;
      s_reg.slot <= SL_NONE;
      s_reg.slot2 <= SL_NONE;
      s_reg.init_kind <= IK_DATA;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign resp_valid = s_reg.resp_valid;
  assign response_code_word = s_reg.rc;
  assign response_data_word = s_reg.rd;
  assign resp_slot = s_reg.slot;
  assign sid2_slot = s_reg.slot2;
  assign lss_on = s_reg.lss;
  assign init_tx_valid = s_reg.init_valid;
  assign init_tx_kind = s_reg.init_kind;
  assign run_mode = s_reg.run;
  assign frame_valid = s_reg.frame_valid;
  assign frame_is_err = s_reg.frame_err;
  assign frame_code = s_reg.frame_code;

endmodule
`default_nettype wire

/* File: design/pdc_pkg.sv */
`default_nettype none
package pdc_pkg;
  // Register map
  localparam logic [7:0] REG_CTRL_OFS      = 8'h00;
  localparam logic [7:0] REG_STATUS_OFS    = 8'h04;
  localparam int         CTRL_LATCH_BIT    = 0;
  localparam int         CTRL_EXT_BIT      = 1;
  localparam int         CTRL_CHAIN_BIT    = 2;
  localparam logic [2:0] CTRL_RESET        = 3'h4;
  localparam int         STAT_ADDR_LSB     = 0;
  localparam int         STAT_STATE_LSB    = 3;
  localparam int         STAT_LSS_BIT      = 6;
  localparam int         STAT_FLAGS_LSB    = 7;
  localparam logic [1:0] AXI_OKAY          = 2'h0;
  localparam logic [1:0] AXI_SLVERR        = 2'h2;

  // Response words
  localparam logic [9:0] RC_OK             = 10'h1e1;
  localparam logic [9:0] RC_ERR            = 10'h1e2;
  localparam logic [9:0] RD_ZERO           = 10'h000;
  localparam logic [9:0] RD_SW_OFF         = 10'h111;
  localparam logic [2:0] ADDR_NONE         = 3'h0;
  localparam logic [2:0] ADDR_BCAST        = 3'h7;
  localparam logic [2:0] FC_ZERO           = 3'h0;
  localparam logic [2:0] FC_ONES           = 3'h7;

  // Error codes, standard and extended
  localparam logic [9:0] EC_STD_OFFSET     = 10'h1f4;
  localparam logic [9:0] EC_SELFTEST       = 10'h1ea;
  localparam logic [9:0] EC_EXT_COMM       = 10'h1ef;
  localparam logic [9:0] EC_EXT_TEST       = 10'h1ee;
  localparam logic [9:0] EC_EXT_OFFSET     = 10'h1ed;
  localparam logic [9:0] EC_EXT_TEMP       = 10'h1ec;
  localparam logic [9:0] EC_EXT_MEM        = 10'h1eb;

  // Error flag positions
  localparam int         FL_COMM           = 0;
  localparam int         FL_TEST           = 1;
  localparam int         FL_OFFSET         = 2;
  localparam int         FL_TEMP           = 3;
  localparam int         FL_MEM            = 4;
  localparam int         FL_SELF           = 5;
  localparam logic [5:0] FL_TEMPORARY      = 6'h0f;

  // Sync pulses spent in each init phase
  localparam logic [7:0] PH2_SYNC_CNT      = 8'h08;
  localparam logic [7:0] PH3_SYNC_CNT      = 8'h08;

  typedef enum logic [2:0] {
    ST_WAIT_ADDR = 3'b000,
    ST_PROG      = 3'b001,
    ST_PH2       = 3'b011,
    ST_PH3       = 3'b010,
    ST_RUN       = 3'b110,
    ST_OFF       = 3'b111
  } pdc_state_t;

  typedef enum logic [2:0] {
    SL_NONE  = 3'h0,
    SL_DC0   = 3'h1,
    SL_DC1_L = 3'h2,
    SL_DC2_L = 3'h3,
    SL_DC1_H = 3'h4,
    SL_DC2_H = 3'h5,
    SL_DC3_H = 3'h6
  } pdc_slot_t;

  typedef enum logic [1:0] {
    IK_DATA     = 2'h0,
    IK_READY    = 2'h1,
    IK_READY_NL = 2'h2
  } pdc_init_kind_t;
endpackage
`default_nettype wire

/* File: verification/pdc_chain_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module pdc_chain_asserts
  import pdc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Command side
  input  wire logic       cmd_valid,
  input  wire logic       cmd_frame_err,
  input  wire logic       cmd_crc_err,
  input  wire logic       cmd_tx_err,
  input  wire logic       sync_pulse,
  input  wire logic       supply_err,
  input  wire logic       test_mode_on,
  // Outputs
  input  wire logic       resp_valid,
  input  wire logic [9:0] response_code_word,
  input  wire logic       init_tx_valid,
  input  wire logic       run_mode,
  input  wire logic       frame_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_bad_cmd;
    cmd_valid && (cmd_frame_err || cmd_crc_err);
  endsequence
  sequence s_tx_answer;
    cmd_valid && cmd_tx_err ##1 resp_valid;
  endsequence
  sequence s_live_pulse;
    sync_pulse && run_mode && !supply_err;
  endsequence

  a_bad_cmd_quiet: assert property (s_bad_cmd |=> !resp_valid)
    else $error("damaged command answered");
  a_blocked_quiet: assert property (cmd_valid && (supply_err || test_mode_on) |=> !resp_valid)
    else $error("blocked command answered");
  a_tx_err_code: assert property (s_tx_answer |-> response_code_word == RC_ERR)
    else $error("disturbed command not flagged");
  a_ok_code: assert property (resp_valid && !$past(cmd_tx_err) |-> response_code_word == RC_OK)
    else $error("good command not acknowledged");
  a_run_frame: assert property (s_live_pulse |=> frame_valid)
    else $error("sync pulse in run without frame");
  a_supply_skip: assert property (sync_pulse && supply_err |=> !init_tx_valid && !frame_valid)
    else $error("sync pulse used during supply error");
  a_run_no_cmd: assert property (run_mode && cmd_valid |=> !resp_valid)
    else $error("command answered after run mode");
  a_init_cause: assert property (init_tx_valid |-> $past(sync_pulse) && !$past(supply_err))
    else $error("init message without sync pulse");
endmodule
bind pdc_chain pdc_chain_asserts u_chk (.*);
`default_nettype wire

/* File: verification/pdc_ecu_model.sv */
`timescale 1ns/1ns
`default_nettype none
module pdc_ecu_model
  import pdc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Requests from the bench
  input  wire logic       go,
  input  wire logic       with_cmd,
  input  wire logic [7:0] n_sync,
  input  wire logic [2:0] m_addr,
  input  wire logic [2:0] m_fc,
  input  wire logic [2:0] m_err,
  output logic            busy,
  // Decoded supply-line side
  output logic            cmd_valid,
  output logic [2:0]      cmd_addr,
  output logic [2:0]      cmd_fc,
  output logic            cmd_frame_err,
  output logic            cmd_crc_err,
  output logic            cmd_tx_err,
  output logic            sync_pulse
);
  localparam logic [7:0] LEAD_SYNC = 8'h1f;
  logic [8:0] cnt;
  logic       send;

  // Fields toggle outside a command so nothing can lean on stale values
  always @(posedge clk) begin
    cmd_valid <= 1'b0;
    sync_pulse <= 1'b0;
    {cmd_addr, cmd_fc, cmd_frame_err, cmd_crc_err, cmd_tx_err} <=
      ~{cmd_addr, cmd_fc, cmd_frame_err, cmd_crc_err, cmd_tx_err};
    if (!rst_n) begin
      busy <= 1'b0;
      cnt <= 9'h000;
      send <= 1'b0;
      {cmd_addr, cmd_fc, cmd_frame_err, cmd_crc_err, cmd_tx_err} <= '0;
    end else if (go && !busy) begin
      busy <= 1'b1;
      send <= with_cmd;
      cnt <= {with_cmd ? LEAD_SYNC : n_sync, 1'b0};
    end else if (busy && cnt != 9'h000) begin
      cnt <= cnt - 9'h001;
      sync_pulse <= cnt[0];
    end else if (busy) begin
      busy <= 1'b0;
      cmd_valid <= send;
      {cmd_addr, cmd_fc, cmd_frame_err, cmd_crc_err, cmd_tx_err} <= {m_addr, m_fc, m_err};
    end
  end
endmodule
`default_nettype wire

/* File: verification/pdc_chain_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module pdc_chain_bench
  import pdc_pkg::*;
;
  logic clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr, n_sync;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, offset_err, selftest_err;
  logic cmd_valid, cmd_frame_err, cmd_crc_err, cmd_tx_err, pme_valid, sync_pulse;
  logic [2:0] cmd_addr, cmd_fc, m_addr, m_fc, m_err, cur, old;
  logic supply_err, comm_err, test_mode_on, temp_err, mem_err, lock_region_programmed;
  logic resp_valid, lss_on, init_tx_valid, run_mode, frame_valid, frame_is_err;
  logic go, with_cmd, busy;
  logic [9:0] response_code_word, response_data_word, frame_code;
  pdc_slot_t resp_slot, sid2_slot;
  pdc_init_kind_t init_tx_kind;
  logic [39:0] q[$];
  int n_mismatch = 0;
  int tests_run = 0;
  pdc_slot_t slot0 [7] = '{SL_NONE, SL_DC0, SL_DC1_L, SL_DC2_L, SL_DC1_H, SL_DC2_H, SL_DC3_H};
  pdc_slot_t slot2 [7] = '{SL_NONE, SL_DC1_L, SL_DC2_L, SL_DC0, SL_DC2_H, SL_DC3_H, SL_DC0};
  logic [2:0] seq [6] = '{3'h5, 3'h1, 3'h2, 3'h4, 3'h6, 3'h3};
  logic [9:0] codes [4] = '{EC_EXT_COMM, EC_EXT_TEST, EC_EXT_OFFSET, EC_EXT_TEMP};

  pdc_chain DUT (.*);
  pdc_ecu_model u_ecu (.*);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic tmo(input bit hit);
    if (hit) begin
      n_mismatch++;
      results();
    end
  endtask
  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic pop(input string nm, input logic [39:0] seen);
    if (q.size() == 0) chk(nm, seen, 40'hff_ffff_ffff);
    else chk(nm, seen, q.pop_front());
  endtask
  task automatic ex(input logic [39:0] x, input int k = 1);
    repeat (k) q.push_back(x);
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  ////////////////////////////////////////////////////////////
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    ex({2'h3, 4'h0, r, 32'h0000_0000});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 60; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    tmo(n == 60);
    @(posedge clk);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    ex({2'h3, 4'h0, r, d});
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 60; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    tmo(n == 60);
    @(posedge clk);
  endtask
  task automatic run_ecu(input logic c, input logic [7:0] ns);
    int n;
    with_cmd <= c;
    n_sync <= ns;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    for (n = 0; n < 600 && busy; n++) @(posedge clk);
    repeat (3) @(posedge clk);
    tmo(n == 600);
  endtask
  task automatic syncs(input logic [7:0] ns);
    run_ecu(1'b0, ns);
  endtask
  task automatic cmd(input logic [2:0] a, f, e, input bit want, input logic [9:0] rc, rd);
    m_addr <= a;
    m_fc <= f;
    m_err <= e;
    if (want) ex({2'h0, 15'h0000, rc, rd, slot0[cur]});
    run_ecu(1'b1, 8'h00);
  endtask
  // Error held two cycles then dropped, so the second frame shows only what is kept
  task automatic flt(input logic [5:0] e, input logic [9:0] c, input logic [9:0] h);
    {selftest_err[1], mem_err, temp_err, offset_err[1], test_mode_on, comm_err} <= e;
    repeat (2) @(posedge clk);
    {selftest_err[1], mem_err, temp_err, offset_err[1], test_mode_on, comm_err} <= 6'h00;
    ex({2'h2, 27'h0, 1'b1, c});
    ex({2'h2, 27'h0, |h, h});
    syncs(8'h02);
  endtask
  ////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (resp_valid) pop("resp", {2'h0, 15'h0, response_code_word, response_data_word, resp_slot});
    if (init_tx_valid) pop("init", {2'h1, 36'h0, init_tx_kind});
    if (frame_valid) pop("frame", {2'h2, 27'h0, frame_is_err, frame_code});
    if (s_axi_rvalid && s_axi_rready) pop("rd", {2'h3, 4'h0, s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) pop("wr", {2'h3, 4'h0, s_axi_bresp, 32'h0000_0000});
  end

  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, go, with_cmd, n_sync} = '0;
    {m_addr, m_fc, m_err, pme_valid, supply_err, comm_err, test_mode_on, temp_err} = '0;
    {offset_err, selftest_err, mem_err, lock_region_programmed, cur} = '0;
    seed = 32'h0000_b7d6;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    axi_rd(REG_CTRL_OFS, 32'h0000_0004, AXI_OKAY);
    axi_rd(8'h08, 32'h0000_0000, AXI_SLVERR);
    seed = lfsr(seed);
    axi_wr(8'h0c, seed, AXI_SLVERR);
    axi_wr(REG_STATUS_OFS, lfsr(seed), AXI_OKAY);
    axi_rd(REG_STATUS_OFS, 32'h0000_0000, AXI_OKAY);
    axi_wr(REG_CTRL_OFS, 32'h0000_0006, AXI_OKAY);
    cmd(3'h3, 3'h0, 3'h0, 0, '0, '0);
    cmd(3'h0, 3'h7, 3'h0, 0, '0, '0);
    cur = 3'h3;
    cmd(3'h0, 3'h3, 3'h0, 1, RC_OK, 10'h003);
    chk("sid2", sid2_slot, SL_DC0);
    cmd(3'h3, 3'h0, 3'h2, 0, '0, '0);
    cmd(3'h3, 3'h0, 3'h4, 0, '0, '0);
    cmd(3'h3, 3'h0, 3'h1, 1, RC_ERR, RD_ZERO);
    cmd(3'h3, 3'h0, 3'h0, 1, RC_OK, RD_ZERO);
    chk("lss", lss_on, 1'b1);
    cmd(3'h3, 3'h7, 3'h0, 1, RC_OK, RD_SW_OFF);
    chk("lss", lss_on, 1'b0);
    foreach (seq[i]) begin
      old = cur;
      cur = seq[i];
      cmd(old, cur, 3'h0, 1, RC_OK, {7'h00, cur});
      chk("sid2", sid2_slot, slot2[cur]);
    end
    supply_err <= 1'b1;
    cmd(3'h3, 3'h0, 3'h0, 0, '0, '0);
    {supply_err, test_mode_on} <= 2'h1;
    cmd(3'h3, 3'h0, 3'h0, 0, '0, '0);
    {test_mode_on, comm_err} <= 2'h1;
    cmd(3'h3, 3'h0, 3'h0, 1, RC_OK, RD_ZERO);
    comm_err <= 1'b0;
    cmd(3'h7, 3'h0, 3'h0, 1, RC_OK, RD_ZERO);
    ex({2'h1, 36'h0, IK_DATA}, 3);
    syncs(8'h03);
    supply_err <= 1'b1;
    syncs(8'h03);
    {supply_err, temp_err} <= 2'h1;
    ex({2'h1, 36'h0, IK_DATA}, 5);
    syncs(8'h05);
    {temp_err, lock_region_programmed} <= 2'h1;
    ex({2'h1, 36'h0, IK_READY}, 4);
    syncs(8'h04);
    {lock_region_programmed, supply_err} <= 2'h1;
    syncs(8'h02);
    supply_err <= 1'b0;
    ex({2'h1, 36'h0, IK_READY_NL}, 4);
    syncs(8'h04);
    chk("run", run_mode, 1'b1);
    ex({2'h2, 27'h0, 1'b1, EC_EXT_TEMP});
    ex({2'h2, 38'h0}, 31);
    syncs(8'h01);
    cmd(3'h3, 3'h0, 3'h0, 0, '0, '0);
    axi_wr(REG_CTRL_OFS, 32'h0000_0004, AXI_OKAY);
    flt(6'h04, EC_STD_OFFSET, 10'h000);
    axi_wr(REG_CTRL_OFS, 32'h0000_0006, AXI_OKAY);
    foreach (codes[i]) flt(6'h01 << i, codes[i], 10'h000);
    flt(6'h10, EC_EXT_MEM, EC_EXT_MEM);
    flt(6'h20, EC_SELFTEST, EC_SELFTEST);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    {rst_n, pme_valid} <= 2'h3;
    @(posedge clk);
    pme_valid <= 1'b0;
    cmd(3'h0, 3'h2, 3'h0, 0, '0, '0);
    axi_rd(REG_STATUS_OFS, 32'h0000_0038, AXI_OKAY);
    chk("left", q.size(), 40'h0);
    results();
  end
endmodule
`default_nettype wire
